// *** logic/cfg_pkg.sv ***
// shared constants and types for the configuration and interlock block
`default_nettype none
package cfg_pkg;
    // mode parameter values
    localparam logic [7:0] MODE_SETTING   = 8'h00;
    localparam logic [7:0] MODE_OPERATION = 8'h01;
    localparam logic [7:0] VAL_ZERO       = 8'h00;
    localparam logic [7:0] VAL_ONE        = 8'h01;
    // parameter codes on the write port
    localparam logic [7:0] CODE_PRESET    = 8'h64;  // 100
    localparam logic [7:0] CODE_IND_FIRST = 8'h65;  // 101
    localparam logic [7:0] CODE_IND_LAST  = 8'h74;  // 116
    localparam logic [7:0] CODE_MODE      = 8'hc6;  // 198
    localparam logic [7:0] CODE_USE       = 8'hc7;  // 199
    localparam logic [7:0] CODE_COMMIT    = 8'h97;  // 151
    localparam logic [7:0] PRESET_MAX     = 8'h0a;
    // control output codes
    localparam logic [7:0] OUT_NONE       = 8'h00;
    localparam logic [7:0] OUT_OPEN       = 8'h14;  // 20
    localparam logic [7:0] OUT_CLOSE      = 8'h15;  // 21
    // object types
    localparam logic [7:0] TYPE_OTHER     = 8'h00;
    localparam logic [7:0] TYPE_BREAKER   = 8'h01;
    localparam logic [7:0] TYPE_TRUCK     = 8'h0b;
    localparam int         NUM_IND        = 16;
    localparam int         MAX_OBJ        = 3;
    localparam logic [1:0] CH_FIRST       = 2'h1;
    localparam logic [1:0] CH_LAST        = 2'h3;
    localparam int         NUM_CH         = 3;
    localparam int         NUM_AUX        = 10;
    // preset table positions
    localparam logic [3:0] PRE_TRUCK_IDX  = 4'h8;
    localparam logic [3:0] PRE_CB_IDX     = 4'h9;
    localparam logic [3:0] PRE_EARTH_IDX  = 4'hf;
    // operand vector layout
    localparam int OP_CLOSED = 0;
    localparam int OP_UNDEF  = 3;
    localparam int OP_OPEN   = 6;
    localparam int OP_AUX    = 9;
    localparam int OP_REG60  = 19;
    localparam int OP_REG61  = 20;
    localparam int OP_LR     = 21;
    localparam int NUM_OPS   = 22;
    // evaluation period
    localparam int CLK_HZ          = 20_000_000;
    localparam int EVAL_PERIOD_MS  = 20;
    localparam int EVAL_CYCLES_DEF = CLK_HZ / 1000 * EVAL_PERIOD_MS;
    localparam int CNT_W           = $clog2(EVAL_CYCLES_DEF);

    typedef struct packed {
        logic       in_use;
        logic       vertical;
        logic [1:0] channel;
        logic [7:0] out_code;
        logic [7:0] obj_type;
    } ind_cfg_t;
    typedef ind_cfg_t [NUM_IND-1:0] ind_table_t;

    typedef struct packed {
        logic               en;
        logic [NUM_OPS-1:0] care;
        logic [NUM_OPS-1:0] val;
    } term_t;
    // index {close, term}
    typedef term_t [3:0] prog_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
        logic [7:0] value;
        ind_cfg_t   entry;
    } param_wr_t;

    typedef struct packed {
        logic  valid;
        logic  close_sel;
        logic  term_sel;
        term_t term;
    } prog_wr_t;

    typedef struct packed {
        logic open;
        logic close;
    } cmd_t;

    typedef struct packed {
        logic [NUM_CH-1:0]  open_contact;
        logic [NUM_CH-1:0]  closed_contact;
        logic [NUM_AUX-1:0] aux;
        logic               lr_remote;
    } chan_pins_t;
endpackage : cfg_pkg
`default_nettype wire

// *** logic/interlock_eval.sv ***
// periodic evaluation of the interlock program into output enables
`timescale 1ns/1ns
`default_nettype none
module interlock_eval #(
    parameter int unsigned EVAL_CYCLES = cfg_pkg::EVAL_CYCLES_DEF
) (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic                        ce,
    input  wire logic                        run,
    input  wire cfg_pkg::prog_t              prog,
    input  wire logic [cfg_pkg::NUM_OPS-1:0] ops,
    output var  cfg_pkg::cmd_t               enable
);
    import cfg_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic [3:0]       hit;
    logic             tick;

    function automatic logic term_hit(input term_t t, input logic [NUM_OPS-1:0] o);
        term_hit = t.en && ((o & t.care) == (t.val & t.care));
    endfunction : term_hit

    for (genvar g = 0; g < 4; g++) begin : g_term
        assign hit[g] = term_hit(prog[g], ops);
    end
    assign tick = (cnt_r == '0);

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (ce) begin
            if (!run || tick) begin
                cnt_r <= CNT_W'(EVAL_CYCLES - 1);
            end else begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    // run only in operation
    // enables hold between evaluations, dropped at once when leaving run
    always_ff @(posedge mclk) begin
        if (rst) begin
            enable <= '0;
        end else if (ce) begin
            if (!run) begin
                enable <= '0;
            end else if (tick) begin
                enable.open  <= hit[0] | hit[1];
                enable.close <= hit[2] | hit[3];
            end
        end
    end
endmodule : interlock_eval
`default_nettype wire

// *** logic/switchgear_config_interlock.sv ***
// object configuration store, validation and interlock gating of control outputs
`timescale 1ns/1ns
`default_nettype none
module switchgear_config_interlock #(
    parameter int unsigned EVAL_CYCLES = cfg_pkg::EVAL_CYCLES_DEF
) (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic                ce,
    input  wire cfg_pkg::param_wr_t  param_wr,
    input  wire cfg_pkg::prog_wr_t   prog_wr,
    output logic                     wr_ack,
    output logic                     wr_err,
    output logic                     store_strobe,
    input  wire logic [7:0]          rd_code,
    output var  cfg_pkg::ind_cfg_t   rd_data,
    output var  cfg_pkg::ind_table_t all_cfg,
    input  wire cfg_pkg::chan_pins_t chan_pins,
    input  wire cfg_pkg::cmd_t       pb_cmd,
    input  wire cfg_pkg::cmd_t       aux_cmd,
    input  wire cfg_pkg::cmd_t       bus_cmd,
    output logic                     run_mode_select,
    output logic                     interlock_in_use,
    output logic [7:0]               config_preset_select,
    output var  cfg_pkg::cmd_t       ctrl_enable,
    output var  cfg_pkg::cmd_t       ctrl_out
);
    import cfg_pkg::*;

    localparam int PIN_W = $bits(chan_pins_t) + 2 * $bits(cmd_t);

    ind_table_t       table_r;
    prog_t            prog_r;
    logic             mode_r;
    logic             use_r;
    logic [7:0]       preset_r;
    logic             ack_r;
    logic             err_r;
    logic             store_r;
    ind_cfg_t         rd_r;
    cmd_t             out_r;
    logic [PIN_W-1:0] pin_s1_r;
    logic [PIN_W-1:0] pin_s2_r;

    chan_pins_t         pins;
    cmd_t               pb_s;
    cmd_t               aux_s;
    logic [NUM_OPS-1:0] ops;
    cmd_t               en_eval;
    cmd_t               cmd_any;
    cmd_t               allow;

    // entry normalising: unused entry stores as all zero
    function automatic ind_cfg_t norm(input ind_cfg_t e);
        ind_cfg_t n;
        n = e;
        if (!e.in_use) begin
            n = '0;
        end else if (e.out_code == OUT_NONE && !type_ok(e.obj_type)) begin
            n.obj_type = TYPE_OTHER;
        end
        return n;
    endfunction : norm

    function automatic logic type_ok(input logic [7:0] t);
        type_ok = (t == TYPE_OTHER) || (t == TYPE_BREAKER) || (t == TYPE_TRUCK);
    endfunction : type_ok

    function automatic logic is_ctrl(input logic [7:0] c);
        is_ctrl = (c == OUT_OPEN) || (c == OUT_CLOSE);
    endfunction : is_ctrl

    // whole-table check, run on the candidate table before storing
    function automatic logic table_ok(input ind_table_t t);
        logic [4:0]        n_obj;
        logic [4:0]        n_ctl;
        logic [4:0]        n_cb;
        logic [4:0]        n_tr;
        logic [NUM_CH-1:0] used;
        logic              bad;
        n_obj = '0;
        n_ctl = '0;
        n_cb  = '0;
        n_tr  = '0;
        used  = '0;
        bad   = 1'b0;
        for (int i = 0; i < NUM_IND; i++) begin
            if (t[i].in_use) begin
                n_obj = n_obj + 5'h01;
                if (t[i].channel < CH_FIRST || t[i].channel > CH_LAST) begin
                    bad = 1'b1;
                end else if (used[t[i].channel - CH_FIRST]) begin
                    bad = 1'b1;
                end else begin
                    used[t[i].channel - CH_FIRST] = 1'b1;
                end
                if (is_ctrl(t[i].out_code)) begin
                    n_ctl = n_ctl + 5'h01;
                end else if (t[i].out_code != OUT_NONE) begin
                    bad = 1'b1;
                end
                if (!type_ok(t[i].obj_type)) begin
                    bad = 1'b1;
                end
                if (t[i].obj_type == TYPE_BREAKER) begin
                    n_cb = n_cb + 5'h01;
                end
                if (t[i].obj_type == TYPE_TRUCK) begin
                    n_tr = n_tr + 5'h01;
                end
            end
        end
        if (n_obj > 5'(MAX_OBJ) || n_ctl > 5'h01) begin
            bad = 1'b1;
        end
        if (n_cb > 5'h01 || n_tr > 5'h01) begin
            bad = 1'b1;
        end
        return !bad;
    endfunction : table_ok

    // preset tables: preset 0 is empty, preset 1 is the base layout, others rotate its indicators
    function automatic ind_table_t preset_table(input logic [7:0] p);
        ind_table_t t;
        logic [3:0] s;
        t = '0;
        s = 4'(p - 8'h01);
        if (p != MODE_SETTING) begin
            t[4'(PRE_TRUCK_IDX + s)] = '{1'b1, 1'b1, CH_FIRST, OUT_NONE, TYPE_TRUCK};
            t[4'(PRE_CB_IDX + s)]    = '{1'b1, 1'b1, 2'h2, OUT_OPEN, TYPE_BREAKER};
            t[4'(PRE_EARTH_IDX + s)] = '{1'b1, 1'b0, CH_LAST, OUT_NONE, TYPE_OTHER};
        end
        return t;
    endfunction : preset_table

    // default program: open always; close with truck closed or open and earth open
    function automatic prog_t preset_prog(input logic [7:0] p);
        prog_t g;
        g = '0;
        if (p != MODE_SETTING) begin
            g[0].en = 1'b1;
            g[2].en = 1'b1;
            g[2].care[OP_CLOSED] = 1'b1;
            g[2].val[OP_CLOSED]  = 1'b1;
            g[2].care[OP_OPEN + 2] = 1'b1;
            g[2].val[OP_OPEN + 2]  = 1'b1;
            g[3].en = 1'b1;
            g[3].care[OP_OPEN] = 1'b1;
            g[3].val[OP_OPEN]  = 1'b1;
            g[3].care[OP_OPEN + 2] = 1'b1;
            g[3].val[OP_OPEN + 2]  = 1'b1;
        end
        return g;
    endfunction : preset_prog

    // pins from the field pass two flops
    assign {pins, pb_s, aux_s} = pin_s2_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else if (ce) begin
            pin_s1_r <= {chan_pins, pb_cmd, aux_cmd};
            pin_s2_r <= pin_s1_r;
        end
    end

    always_comb begin
        ops = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            ops[OP_CLOSED + c] = pins.closed_contact[c] & ~pins.open_contact[c];
            ops[OP_OPEN + c]   = pins.open_contact[c] & ~pins.closed_contact[c];
            ops[OP_UNDEF + c]  = ~(pins.open_contact[c] ^ pins.closed_contact[c]);
        end
        ops[OP_AUX +: NUM_AUX] = pins.aux;
        ops[OP_REG60] = 1'b0;
        ops[OP_REG61] = 1'b1;
        ops[OP_LR]    = pins.lr_remote;
    end

    interlock_eval #(
        .EVAL_CYCLES (EVAL_CYCLES)
    ) u_eval (
        .mclk   (mclk),
        .rst    (rst),
        .ce     (ce),
        .run    (mode_r & use_r),
        .prog   (prog_r),
        .ops    (ops),
        .enable (en_eval)
    );

    // write decode
    wire             wr_v      = param_wr.valid;
    wire             setting   = !mode_r;
    wire             is_ind    = param_wr.code >= CODE_IND_FIRST &&
                                 param_wr.code <= CODE_IND_LAST;
    wire [3:0]       ind_idx   = 4'(param_wr.code - CODE_IND_FIRST);
    wire             is_preset = param_wr.code == CODE_PRESET;
    wire             is_mode   = param_wr.code == CODE_MODE;
    wire             is_use    = param_wr.code == CODE_USE;
    wire             is_commit = param_wr.code == CODE_COMMIT;
    wire             val_bit   = param_wr.value == VAL_ONE;
    wire             val_bool  = param_wr.value == VAL_ZERO || val_bit;

    ind_table_t cand;
    always_comb begin
        cand = table_r;
        cand[ind_idx] = norm(param_wr.entry);
    end

    wire ok_ind    = is_ind && setting && table_ok(cand);
    wire ok_preset = is_preset && setting && param_wr.value <= PRESET_MAX;
    wire ok_mode   = is_mode && val_bool && (!val_bit || use_r);
    wire ok_use    = is_use && setting && val_bool;
    wire ok_commit = is_commit && val_bit;
    wire ok_param  = ok_ind | ok_preset | ok_mode | ok_use | ok_commit;
    wire prog_take = prog_wr.valid && !wr_v && setting;
    wire any_req   = wr_v || prog_wr.valid;
    wire any_ok    = (wr_v && ok_param) || prog_take;

    always_ff @(posedge mclk) begin
        if (rst) begin
            table_r  <= preset_table(VAL_ONE);
            prog_r   <= preset_prog(VAL_ONE);
            preset_r <= VAL_ONE;
        end else if (ce) begin
            if (wr_v && ok_ind) begin
                table_r[ind_idx] <= norm(param_wr.entry);
            end else if (wr_v && ok_preset) begin
                table_r  <= preset_table(param_wr.value);
                prog_r   <= preset_prog(param_wr.value);
                preset_r <= param_wr.value;
            end else if (prog_take) begin
                prog_r[{prog_wr.close_sel, prog_wr.term_sel}] <= prog_wr.term;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_r <= 1'b1;
            use_r  <= 1'b1;
        end else if (ce) begin
            if (wr_v && ok_mode) begin
                mode_r <= val_bit;
            end
            if (wr_v && ok_use) begin
                use_r <= val_bit;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_r   <= 1'b0;
            err_r   <= 1'b0;
            store_r <= 1'b0;
        end else if (ce) begin
            ack_r   <= any_ok;
            err_r   <= any_req && !any_ok;
            store_r <= wr_v && ok_commit;
        end
    end

    wire rd_hit = rd_code >= CODE_IND_FIRST && rd_code <= CODE_IND_LAST;
    wire [3:0] rd_idx = 4'(rd_code - CODE_IND_FIRST);

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_r <= '0;
        end else if (ce) begin
            rd_r <= rd_hit ? table_r[rd_idx] : '0;
        end
    end

    // a control object must exist for outputs to move
    logic ctrl_obj;
    always_comb begin
        ctrl_obj = 1'b0;
        for (int i = 0; i < NUM_IND; i++) begin
            ctrl_obj = ctrl_obj | (table_r[i].in_use & is_ctrl(table_r[i].out_code));
        end
    end

    assign cmd_any = pb_s | aux_s | bus_cmd;

    assign allow.open  = ctrl_obj & (use_r ? (mode_r & en_eval.open) : 1'b1);
    assign allow.close = ctrl_obj & (use_r ? (mode_r & en_eval.close) : 1'b1);

    // open wins over close when both are requested, never both at once
    always_ff @(posedge mclk) begin
        if (rst) begin
            out_r <= '0;
        end else if (ce) begin
            out_r.open  <= cmd_any.open & allow.open;
            out_r.close <= cmd_any.close & allow.close & ~cmd_any.open;
        end
    end

    assign wr_ack               = ack_r;
    assign wr_err               = err_r;
    assign store_strobe         = store_r;
    assign rd_data              = rd_r;
    assign all_cfg              = table_r;
    assign run_mode_select      = mode_r;
    assign interlock_in_use     = use_r;
    assign config_preset_select = preset_r;
    assign ctrl_enable          = allow;
    assign ctrl_out             = out_r;
endmodule : switchgear_config_interlock
`default_nettype wire

// *** tb/sci_checker.sv ***
// assertion checker for the configuration and interlock block
`timescale 1ns/1ns
`default_nettype none
module sci_checker
    import cfg_pkg::*;
#(
    parameter int unsigned EVAL_CYCLES = 20
) (
    input wire logic                mclk,
    input wire logic                rst,
    input wire logic                ce,
    input wire cfg_pkg::param_wr_t  param_wr,
    input wire cfg_pkg::prog_wr_t   prog_wr,
    input wire logic                wr_ack,
    input wire logic                wr_err,
    input wire logic                store_strobe,
    input wire logic [7:0]          rd_code,
    input wire cfg_pkg::ind_cfg_t   rd_data,
    input wire cfg_pkg::ind_table_t all_cfg,
    input wire logic                run_mode_select,
    input wire logic                interlock_in_use,
    input wire cfg_pkg::cmd_t       ctrl_enable,
    input wire cfg_pkg::cmd_t       ctrl_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire ind_wr = param_wr.valid && param_wr.code >= CODE_IND_FIRST
                  && param_wr.code <= CODE_IND_LAST;
    sequence s_mode_up;
        param_wr.valid && param_wr.code == CODE_MODE && param_wr.value == MODE_OPERATION;
    endsequence
    sequence s_refused;
        wr_err && !wr_ack;
    endsequence
    AST_ANSWER: assert property (ce && (param_wr.valid || prog_wr.valid) |=> wr_ack != wr_err)
        else $error("write not answered exactly once");
    AST_NO_SPURIOUS: assert property ($past(ce) && (wr_ack || wr_err) |->
        $past(param_wr.valid || prog_wr.valid))
        else $error("answer without request");
    AST_CFG_LOCK: assert property (ce && run_mode_select && ind_wr |=> s_refused ##0 $stable(all_cfg))
        else $error("indicator write taken in operation mode");
    AST_MODE_REFUSE: assert property ((ce && !interlock_in_use) ##0 s_mode_up |=> s_refused ##0 !run_mode_select)
        else $error("operation mode entered without interlock");
    AST_OP_NEEDS_USE: assert property (run_mode_select |-> interlock_in_use)
        else $error("operation mode with interlock unused");
    AST_SET_BLOCK: assert property (!run_mode_select && interlock_in_use |-> ctrl_enable == 2'b00)
        else $error("control allowed in setting mode");
    AST_GATE: assert property (ce |=> (ctrl_out & ~$past(ctrl_enable)) == 2'b00)
        else $error("output driven without enable");
    AST_OPEN_WINS: assert property (!(ctrl_out.open && ctrl_out.close))
        else $error("open and close driven together");
    AST_STROBE: assert property ($past(ce) && store_strobe |-> wr_ack &&
        $past(param_wr.code) == CODE_COMMIT && $past(param_wr.value) == VAL_ONE)
        else $error("store strobe without commit of one");
    AST_READ_ZERO: assert property (ce && (rd_code < CODE_IND_FIRST || rd_code > CODE_IND_LAST) |=> rd_data == 20'h00000)
        else $error("readback outside table not zero");
endmodule : sci_checker
bind switchgear_config_interlock sci_checker #(.EVAL_CYCLES(EVAL_CYCLES)) chk_i (
    .mclk(mclk), .rst(rst), .ce(ce), .param_wr(param_wr), .prog_wr(prog_wr),
    .wr_ack(wr_ack), .wr_err(wr_err), .store_strobe(store_strobe), .rd_code(rd_code),
    .rd_data(rd_data), .all_cfg(all_cfg), .run_mode_select(run_mode_select),
    .interlock_in_use(interlock_in_use), .ctrl_enable(ctrl_enable), .ctrl_out(ctrl_out));
`default_nettype wire

// *** tb/host_model.sv ***
// host side model: retained copy of the table taken on each store strobe
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic                mclk,
    input  wire logic                store_strobe,
    input  wire cfg_pkg::ind_table_t all_cfg,
    output var  cfg_pkg::ind_table_t kept
);
    always_ff @(posedge mclk) begin
        if (store_strobe) begin
            kept <= all_cfg;
        end
    end
endmodule : host_model
`default_nettype wire

// *** tb/switchgear_config_interlock_bench.sv ***
// self-checking bench for the configuration and interlock block
`timescale 1ns/1ns
`default_nettype none
module switchgear_config_interlock_bench;
    import cfg_pkg::*;
    localparam int EC = 20;
    localparam ind_cfg_t Z = '0;
    logic mclk, rst, ce, wr_ack, wr_err, store_strobe, run_mode_select, interlock_in_use;
    logic [7:0] rd_code, config_preset_select;
    param_wr_t  param_wr;
    prog_wr_t   prog_wr;
    ind_cfg_t   rd_data;
    ind_table_t all_cfg, kept;
    chan_pins_t chan_pins;
    cmd_t       pb_cmd, aux_cmd, bus_cmd, ctrl_enable, ctrl_out;
    int         n_mismatch, compares, cycles, n;

    switchgear_config_interlock #(.EVAL_CYCLES(EC)) dut (
        .mclk(mclk), .rst(rst), .ce(ce), .param_wr(param_wr), .prog_wr(prog_wr),
        .wr_ack(wr_ack), .wr_err(wr_err), .store_strobe(store_strobe), .rd_code(rd_code),
        .rd_data(rd_data), .all_cfg(all_cfg), .chan_pins(chan_pins), .pb_cmd(pb_cmd),
        .aux_cmd(aux_cmd), .bus_cmd(bus_cmd), .run_mode_select(run_mode_select),
        .interlock_in_use(interlock_in_use), .config_preset_select(config_preset_select),
        .ctrl_enable(ctrl_enable), .ctrl_out(ctrl_out));
    host_model host (.mclk(mclk), .store_strobe(store_strobe), .all_cfg(all_cfg), .kept(kept));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task tick;
        @(posedge mclk);
        #5;
    endtask : tick
    task chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask : chk
    // answer shows right after the taking edge
    task req(input logic err, input logic stb);
        tick();
        param_wr.valid = 1'b0;
        prog_wr.valid = 1'b0;
        chk(wr_err === err && wr_ack === !err && store_strobe === stb, "write answer");
        tick();
    endtask : req
    task wr(input logic [7:0] c, input logic [7:0] v, input ind_cfg_t e, input logic err);
        param_wr = {1'b1, c, v, e};
        req(err, c == CODE_COMMIT && !err);
    endtask : wr
    task pw(input logic cs, input logic [21:0] care, input logic [21:0] val, input logic err);
        prog_wr = {1'b1, cs, 1'b0, 1'b1, care, val};
        req(err, 1'b0);
    endtask : pw
    function ind_cfg_t ent(input logic v, input logic [1:0] ch, input logic [7:0] oc,
                           input logic [7:0] ty);
        return {1'b1, v, ch, oc, ty};
    endfunction : ent
    task end_sim;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        param_wr = '0;
        prog_wr = '0;
        rd_code = CODE_IND_FIRST;
        chan_pins = '0;
        pb_cmd = '0;
        aux_cmd = '0;
        bus_cmd = '0;
        n_mismatch = 0;
        compares = 0;
        cycles = 0;
        repeat (8) @(posedge mclk);
        #5;
        rst = 1'b0;
        rd_code = 8'h6e;
        tick();
        chk(run_mode_select === 1'b1 && interlock_in_use === 1'b1, "reset mode");
        chk(config_preset_select === 8'h01, "reset preset");
        chk(all_cfg[8] === ent(1'b1, 2'h1, OUT_NONE, TYPE_TRUCK), "reset 109");
        chk(all_cfg[15] === ent(1'b0, 2'h3, OUT_NONE, TYPE_OTHER), "reset 116");
        chk(rd_data === ent(1'b1, 2'h2, OUT_OPEN, TYPE_BREAKER), "read 110");
        chk(ctrl_enable.open === 1'b1 && ctrl_enable.close === 1'b0, "reset program");
        rd_code = CODE_PRESET;
        tick();
        chk(rd_data === Z, "read outside table");
        wr(8'h6d, 8'h00, ent(1'b1, 2'h1, OUT_NONE, TYPE_TRUCK), 1'b1);
        pw(1'b0, 22'h000001, 22'h000001, 1'b1);
        wr(CODE_MODE, MODE_SETTING, Z, 1'b0);
        chk(run_mode_select === 1'b0, "setting mode");
        bus_cmd.open = 1'b1;
        tick();
        chk(ctrl_out.open === 1'b0, "setting mode blocks");
        bus_cmd.open = 1'b0;
        wr(CODE_PRESET, 8'h0b, Z, 1'b1);
        wr(CODE_PRESET, PRESET_MAX, Z, 1'b0);
        chk(config_preset_select === 8'h0a, "preset ten");
        chk(all_cfg[1] === ent(1'b1, 2'h1, OUT_NONE, TYPE_TRUCK), "preset ten table");
        wr(CODE_PRESET, 8'h00, Z, 1'b0);
        chk(all_cfg === '0, "free table empty");
        wr(CODE_IND_FIRST, 8'h00, ent(1'b0, 2'h1, OUT_OPEN, TYPE_BREAKER), 1'b0);
        wr(8'h66, 8'h00, ent(1'b0, 2'h1, OUT_NONE, TYPE_OTHER), 1'b1);
        wr(8'h66, 8'h00, ent(1'b0, 2'h0, OUT_NONE, TYPE_OTHER), 1'b1);
        wr(8'h66, 8'h00, ent(1'b0, 2'h2, OUT_CLOSE, TYPE_OTHER), 1'b1);
        wr(8'h66, 8'h00, ent(1'b0, 2'h2, 8'h16, TYPE_OTHER), 1'b1);
        wr(8'h66, 8'h00, ent(1'b0, 2'h2, OUT_NONE, TYPE_TRUCK), 1'b0);
        wr(8'h67, 8'h00, ent(1'b0, 2'h3, OUT_NONE, TYPE_TRUCK), 1'b1);
        wr(8'h67, 8'h00, ent(1'b0, 2'h3, OUT_NONE, TYPE_OTHER), 1'b0);
        wr(8'h68, 8'h00, ent(1'b0, 2'h1, OUT_NONE, TYPE_OTHER), 1'b1);
        wr(8'h69, 8'h00, 20'h7ffff, 1'b0);
        chk(all_cfg[4] === Z, "unused entry zero");
        chk(all_cfg[0] === ent(1'b0, 2'h1, OUT_OPEN, TYPE_BREAKER), "entry 101");
        pw(1'b0, 22'h000001, 22'h000001, 1'b0);
        pw(1'b1, 22'h180000, 22'h100000, 1'b0);
        wr(CODE_MODE, MODE_OPERATION, Z, 1'b0);
        n = 0;
        while (ctrl_enable.close !== 1'b1 && n < 60) begin
            tick();
            n++;
        end
        chk(ctrl_enable.close === 1'b1 && n <= EC + 3, "close enable");
        chk(ctrl_enable.open === 1'b0, "open not enabled");
        bus_cmd.open = 1'b1;
        tick();
        chk(ctrl_out.open === 1'b0, "open inhibited");
        chan_pins.closed_contact = 3'b001;
        n = 0;
        while (ctrl_enable.open !== 1'b1 && n < 60) begin
            tick();
            n++;
        end
        chk(ctrl_enable.open === 1'b1 && n <= EC + 4, "open enable");
        tick();
        chk(ctrl_out.open === 1'b1, "open passed");
        // enable must hold until the next evaluation
        chan_pins.closed_contact = 3'b000;
        n = 0;
        while (ctrl_enable.open === 1'b1 && n < 60) begin
            tick();
            n++;
        end
        chk(n >= EC - 2 && n <= EC + 1, "evaluation period");
        bus_cmd.open = 1'b0;
        chan_pins.lr_remote = 1'b1;
        aux_cmd.close = 1'b1;
        repeat (3) tick();
        chk(ctrl_out.close === 1'b1, "remote aux close");
        aux_cmd.close = 1'b0;
        wr(CODE_MODE, MODE_SETTING, Z, 1'b0);
        wr(CODE_USE, VAL_ZERO, Z, 1'b0);
        chk(interlock_in_use === 1'b0, "interlock unused");
        wr(CODE_MODE, MODE_OPERATION, Z, 1'b1);
        pb_cmd.open = 1'b1;
        repeat (3) tick();
        chk(ctrl_out.open === 1'b1, "ungated open");
        pb_cmd.open = 1'b0;
        // clock enable low: a write must be neither taken nor answered
        ce = 1'b0;
        param_wr = {1'b1, CODE_USE, VAL_ONE, Z};
        repeat (2) tick();
        chk(wr_ack === 1'b0 && wr_err === 1'b0 && interlock_in_use === 1'b0, "ce freeze");
        param_wr.valid = 1'b0;
        ce = 1'b1;
        tick();
        wr(CODE_COMMIT, VAL_ONE, Z, 1'b0);
        chk(kept[0] === ent(1'b0, 2'h1, OUT_OPEN, TYPE_BREAKER), "kept 101");
        chk(kept[1] === ent(1'b0, 2'h2, OUT_NONE, TYPE_TRUCK), "kept 102");
        wr(CODE_COMMIT, 8'h02, Z, 1'b1);
        wr(8'h33, 8'h00, Z, 1'b1);
        end_sim();
    end
endmodule : switchgear_config_interlock_bench
`default_nettype wire
